// file: rtl/pxm_pkg.sv
// Functional notes
// - Each placed function takes the lowest free pin, two-wire bus first; serial pins are fixed.
// - Pins already given to higher-priority functions are passed over.
// - Pins whose skip bit is set are treated as already assigned.
// - Skip mask bit n matches port pin n; 0x44 skips pins 6 and 2.
// - Serial transmit sits on pin 4, serial receive on pin 5.
// - Serial transmit and receive are selected independently.
// - The two-wire bus claims two pins together, data then clock.
// - Unclaimed pins stay general purpose after the assigned ones.
// - With routing disabled every pin has its driver off; analog pins stay analog.
// - Input mode bit 1 means digital, 0 analog; reset gives digital.
// - Analog pins have pull-up, driver and receiver all disabled.
// - Output mode bit picks open-drain or push-pull, routed pins too.
// - Two-wire bus pins are always open-drain.
// - Pull-up disable at 0 enables pull-ups on open-drain pins only.
// - An open-drain pin driving low has its pull-up switched off.
// - Port reads return the pin level even for routed pins.
// - Compare output field routes zero to three compare outputs.
// - A port bit of an analog pin always reads 1.
// - Output mode is ignored while the pin is analog.
package pxm_pkg;

   localparam int PXM_PINS = 8;
   localparam int PXM_FN_COUNT = 11;

   // Prioritized function table, highest priority first.
   localparam int FN_SDA = 0;
   localparam int FN_SCL = 1;
   localparam int FN_CP0 = 2;
   localparam int FN_CP0A = 3;
   localparam int FN_SYSCLK = 4;
   localparam int FN_CMP_OUT0 = 5;
   localparam int FN_CMP_OUT1 = 6;
   localparam int FN_CMP_OUT2 = 7;
   localparam int FN_ECI = 8;
   localparam int FN_T0 = 9;
   localparam int FN_T1 = 10;

   // Functions that drive a pin (1) rather than read it (0).
   localparam logic [PXM_FN_COUNT-1:0] FN_DRIVES = 11'h0FF;
   // Idle value seen by an input function that owns no pin.
   localparam logic [PXM_FN_COUNT-1:0] FN_IDLE = 11'h003;

   // Fixed serial pins.
   localparam int PIN_SERIAL_TX = 4;
   localparam int PIN_SERIAL_RX = 5;

   // Field positions of function_route_reg.
   localparam int RT_TX_EN = 0;
   localparam int RT_RX_EN = 1;
   localparam int RT_BUS_EN = 2;
   localparam int RT_SYSCLK_EN = 3;
   localparam int RT_CP0_EN = 4;
   localparam int RT_CP0A_EN = 5;
   localparam int RT_CMP_LO = 6;
   localparam int RT_CMP_HI = 7;

   // Field positions of route_control_reg.
   localparam int CT_ECI_EN = 0;
   localparam int CT_T0_EN = 1;
   localparam int CT_T1_EN = 2;
   localparam int CT_ROUTE_EN = 6;
   localparam int CT_WEAK_PUD = 7;

   // Only the low seven pins can be skipped.
   localparam logic [7:0] SKIP_BITS_MASK = 8'h7F;

   // Reset values.
   localparam logic [7:0] RST_SKIP = 8'h00;
   localparam logic [7:0] RST_ROUTE = 8'h00;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_IN_MODE = 8'hFF;
   localparam logic [7:0] RST_OUT_MODE = 8'h00;
   localparam logic [7:0] RST_LATCH = 8'hFF;

endpackage : pxm_pkg

// file: rtl/pxm_placer.sv
`timescale 1ns/1ps
module pxm_placer
   import pxm_pkg::*;
(
   input wire logic [PXM_FN_COUNT-1:0] request,
   input wire logic [PXM_PINS-1:0] blocked,
   output logic [PXM_FN_COUNT-1:0][PXM_PINS-1:0] place,
   output logic [PXM_PINS-1:0] claimed
);

   logic [PXM_FN_COUNT:0][PXM_PINS-1:0] avail;
   logic [PXM_FN_COUNT-1:0][PXM_PINS-1:0] lowest;

   // Blocked pins count as taken before any function is placed.
   assign avail[0] = ~blocked;

   genvar k;
   generate
      for (k = 0; k < PXM_FN_COUNT; k++)
      begin : g_fn
         // Lowest set bit of the free pins, in table order.
         assign lowest[k] = avail[k] & PXM_PINS'(~avail[k] + 8'h01);
         assign place[k] = request[k] ? lowest[k] : '0;
         // A placed pin is passed over by every later function.
         assign avail[k+1] = avail[k] & ~place[k];
      end
   endgenerate

   assign claimed = ~avail[PXM_FN_COUNT] & ~blocked;

endmodule : pxm_placer

// file: rtl/pxm_port_mux.sv
`timescale 1ns/1ps
module pxm_port_mux
   import pxm_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic [7:0] WDATA,
   input wire logic SKIP_WE,
   input wire logic ROUTE_WE,
   input wire logic CTRL_WE,
   input wire logic IN_MODE_WE,
   input wire logic OUT_MODE_WE,
   input wire logic LATCH_WE,
   input wire logic SERIAL_TRANSMIT_OUT,
   input wire logic SDA_OUT,
   input wire logic SCL_OUT,
   input wire logic CP0_OUT,
   input wire logic CP0A_OUT,
   input wire logic SYSCLK_OUT,
   input wire logic [2:0] COMPARE_OUT,
   output logic SERIAL_RECEIVE_IN,
   output logic SDA_IN,
   output logic SCL_IN,
   output logic ECI_IN,
   output logic T0_IN,
   output logic T1_IN,
   input wire logic [7:0] PIN_IN,
   output logic [7:0] PIN_OUT,
   output logic [7:0] PIN_OE,
   output logic [7:0] PIN_PULLUP,
   output logic [7:0] PIN_RX_EN,
   output logic [7:0] PORT_READ,
   output logic [7:0] PINS_ASSIGNED
);

   logic [7:0] pin_skip_mask_reg;
   logic [7:0] function_route_reg;
   logic [7:0] route_control_reg;
   logic [7:0] pin_input_mode_mask;
   logic [7:0] pin_output_mode_mask;
   logic [7:0] port_latch;

   logic route_enable_bit;
   logic weak_pullup_disable;
   logic tx_sel;
   logic rx_sel;
   logic [1:0] compare_output_count;
   logic [PXM_FN_COUNT-1:0] request;
   logic [PXM_FN_COUNT-1:0] fn_out;
   logic [PXM_FN_COUNT-1:0] fn_in;
   logic [7:0] fixed_pins;
   logic [7:0] blocked;
   logic [7:0] claimed;
   logic [PXM_FN_COUNT-1:0][7:0] place_raw;
   logic [PXM_FN_COUNT-1:0][7:0] place;
   logic [7:0] pin_level;
   logic [7:0] bus_pins;
   logic [7:0] next_out;
   logic [7:0] next_oe;
   logic [7:0] next_pullup;
   logic [7:0] next_rx_en;
   logic next_rx;

   default clocking chk_clk @(posedge CLK);
   endclocking
   default disable iff (RST);

   // Configuration registers.
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         pin_skip_mask_reg <= RST_SKIP;
         function_route_reg <= RST_ROUTE;
         route_control_reg <= RST_CTRL;
      end
      else
      begin
         if (SKIP_WE)
         begin
            pin_skip_mask_reg <= WDATA & SKIP_BITS_MASK;
         end
         if (ROUTE_WE)
         begin
            function_route_reg <= WDATA;
         end
         if (CTRL_WE)
         begin
            route_control_reg <= WDATA;
         end
      end
   end

   // Pin mode registers and the output latch.
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         pin_input_mode_mask <= RST_IN_MODE;
         pin_output_mode_mask <= RST_OUT_MODE;
         port_latch <= RST_LATCH;
      end
      else
      begin
         if (IN_MODE_WE)
         begin
            pin_input_mode_mask <= WDATA;
         end
         if (OUT_MODE_WE)
         begin
            pin_output_mode_mask <= WDATA;
         end
         if (LATCH_WE)
         begin
            port_latch <= WDATA;
         end
      end
   end

   assign route_enable_bit = route_control_reg[CT_ROUTE_EN];
   assign weak_pullup_disable = route_control_reg[CT_WEAK_PUD];
   assign tx_sel = function_route_reg[RT_TX_EN];
   assign rx_sel = function_route_reg[RT_RX_EN];
   assign compare_output_count = function_route_reg[RT_CMP_HI:RT_CMP_LO];

   // Requests in table order; the bus bit asks for two pins.
   always_comb
   begin
      request = '0;
      request[FN_SDA] = function_route_reg[RT_BUS_EN];
      request[FN_SCL] = function_route_reg[RT_BUS_EN];
      request[FN_CP0] = function_route_reg[RT_CP0_EN];
      request[FN_CP0A] = function_route_reg[RT_CP0A_EN];
      request[FN_SYSCLK] = function_route_reg[RT_SYSCLK_EN];
      request[FN_CMP_OUT0] = compare_output_count != 2'b00;
      request[FN_CMP_OUT1] = compare_output_count[1];
      request[FN_CMP_OUT2] = compare_output_count == 2'b11;
      request[FN_ECI] = route_control_reg[CT_ECI_EN];
      request[FN_T0] = route_control_reg[CT_T0_EN];
      request[FN_T1] = route_control_reg[CT_T1_EN];
   end

   // Values that driving functions put on their pins.
   always_comb
   begin
      fn_out = '0;
      fn_out[FN_SDA] = SDA_OUT;
      fn_out[FN_SCL] = SCL_OUT;
      fn_out[FN_CP0] = CP0_OUT;
      fn_out[FN_CP0A] = CP0A_OUT;
      fn_out[FN_SYSCLK] = SYSCLK_OUT;
      fn_out[FN_CMP_OUT0] = COMPARE_OUT[0];
      fn_out[FN_CMP_OUT1] = COMPARE_OUT[1];
      fn_out[FN_CMP_OUT2] = COMPARE_OUT[2];
   end

   // Selected serial pins are out of reach of the priority placement.
   always_comb
   begin
      fixed_pins = '0;
      fixed_pins[PIN_SERIAL_TX] = tx_sel;
      fixed_pins[PIN_SERIAL_RX] = rx_sel;
   end

   assign blocked = pin_skip_mask_reg | fixed_pins;

   // Placement follows the registers with no state of its own.
   pxm_placer u_placer
   (
      .request(request),
      .blocked(blocked),
      .place(place_raw),
      .claimed(claimed)
   );

   // Placement only takes hold while routing is enabled.
   assign place = route_enable_bit ? place_raw : '0;

   assign bus_pins = place[FN_SDA] | place[FN_SCL];

   genvar p;
   genvar f;
   generate
      for (p = 0; p < PXM_PINS; p++)
      begin : g_pin
         logic owned;
         logic drive_fn;
         logic [PXM_FN_COUNT-1:0] owners;
         logic value;
         logic digital;
         logic push_pull;
         logic serial_tx_pin;

         for (f = 0; f < PXM_FN_COUNT; f++)
         begin : g_own
            assign owners[f] = place[f][p];
         end

         assign digital = pin_input_mode_mask[p];
         assign serial_tx_pin = (p == PIN_SERIAL_TX) && tx_sel &&
            route_enable_bit;
         assign owned = |(owners & FN_DRIVES);
         assign drive_fn = |(owners & FN_DRIVES & fn_out);

         chk_skip_honoured: assert property (
            !(pin_skip_mask_reg[p] && (|owners)))
            else $error("skipped pin was assigned");

         // Analog pins read back 1; receiver off.
         assign pin_level[p] = digital ? PIN_IN[p] : 1'b1;

         always_comb
         begin
            if (serial_tx_pin)
            begin
               value = SERIAL_TRANSMIT_OUT;
            end
            else if (owned)
            begin
               value = drive_fn;
            end
            else
            begin
               // Unclaimed pins stay general purpose and follow the latch.
               value = port_latch[p];
            end
            // Output mode applies to routed pins; bus pins stay open-drain.
            push_pull = pin_output_mode_mask[p] && !bus_pins[p];
            next_out[p] = value;
            if (!route_enable_bit || !digital)
            begin
               next_oe[p] = 1'b0;
            end
            else if (push_pull)
            begin
               next_oe[p] = 1'b1;
            end
            else
            begin
               next_oe[p] = !value;
            end
            // Mode bit is not consulted while the pin is analog.
            next_pullup[p] = digital && !push_pull &&
               !weak_pullup_disable && !next_oe[p];
            next_rx_en[p] = digital;
         end
      end
   endgenerate

   // Inputs seen by reading functions, idle when they own no pin.
   generate
      for (f = 0; f < PXM_FN_COUNT; f++)
      begin : g_fn_in
         assign fn_in[f] = (|place[f]) ? |(place[f] & pin_level) : FN_IDLE[f];
      end
   endgenerate

   assign next_rx = (route_enable_bit && rx_sel) ?
      pin_level[PIN_SERIAL_RX] : 1'b1;

   // Pin drivers.
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         PIN_OUT <= 8'hFF;
         PIN_OE <= 8'h00;
         PIN_PULLUP <= 8'h00;
         PIN_RX_EN <= 8'hFF;
      end
      else
      begin
         PIN_OUT <= next_out;
         PIN_OE <= next_oe;
         PIN_PULLUP <= next_pullup;
         PIN_RX_EN <= next_rx_en;
      end
   end

   // Port readback and status.
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         PORT_READ <= 8'hFF;
         PINS_ASSIGNED <= 8'h00;
      end
      else
      begin
         PORT_READ <= pin_level;
         PINS_ASSIGNED <= route_enable_bit ? (claimed | fixed_pins) : 8'h00;
      end
   end

   // Peripheral inputs.
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         SERIAL_RECEIVE_IN <= 1'b1;
         SDA_IN <= 1'b1;
         SCL_IN <= 1'b1;
         ECI_IN <= 1'b0;
         T0_IN <= 1'b0;
         T1_IN <= 1'b0;
      end
      else
      begin
         SERIAL_RECEIVE_IN <= next_rx;
         SDA_IN <= fn_in[FN_SDA];
         SCL_IN <= fn_in[FN_SCL];
         ECI_IN <= fn_in[FN_ECI];
         T0_IN <= fn_in[FN_T0];
         T1_IN <= fn_in[FN_T1];
      end
   end

   // Checks.
   sequence s_enable_write;
      CTRL_WE && WDATA[CT_ROUTE_EN];
   endsequence

   sequence s_enable_held;
      route_enable_bit [*2];
   endsequence

   chk_disabled_quiet: assert property (
      !route_enable_bit |=> PIN_OE == 8'h00)
      else $error("pin driven while routing disabled");

   chk_enable_takes: assert property (
      s_enable_write ##1 !CTRL_WE |-> s_enable_held ##0
      ((~PIN_OE & $past(pin_output_mode_mask & pin_input_mode_mask &
      ~bus_pins)) == 8'h00))
      else $error("routing enable did not take hold");

   chk_analog_quiet: assert property (
      1'b1 |=> ((PIN_OE | PIN_PULLUP | PIN_RX_EN) &
      ~$past(pin_input_mode_mask)) == 8'h00)
      else $error("analog pin not fully disabled");

   chk_analog_reads: assert property (
      1'b1 |=> (PORT_READ | $past(pin_input_mode_mask)) == 8'hFF)
      else $error("analog pin read not one");

   chk_pin_read: assert property (
      !RST |=> ((PORT_READ ^ $past(PIN_IN)) &
      $past(pin_input_mode_mask)) == 8'h00)
      else $error("port read differs from pin");

   chk_tx_fixed: assert property (
      route_enable_bit && tx_sel && pin_input_mode_mask[PIN_SERIAL_TX]
      |=> PIN_OUT[PIN_SERIAL_TX] == $past(SERIAL_TRANSMIT_OUT))
      else $error("serial transmit not on pin 4");

   chk_rx_fixed: assert property (
      route_enable_bit && rx_sel && pin_input_mode_mask[PIN_SERIAL_RX]
      |=> SERIAL_RECEIVE_IN == $past(PIN_IN[PIN_SERIAL_RX]))
      else $error("serial receive not from pin 5");

   chk_bus_open_drain: assert property (
      1'b1 |=> (PIN_OE & PIN_OUT & $past(bus_pins)) == 8'h00)
      else $error("bus pin driven high");

   chk_pullup_low: assert property (
      (PIN_PULLUP & PIN_OE) == 8'h00)
      else $error("pull-up on while driving low");

   chk_pullup_off: assert property (
      weak_pullup_disable |=> PIN_PULLUP == 8'h00)
      else $error("pull-up on while disabled");

endmodule : pxm_port_mux

// file: testbench/pxm_board.sv
`timescale 1ns/1ps
module pxm_board
   import pxm_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pin_pullup,
   input wire logic [7:0] pull_low,
   output logic [7:0] level
);
   logic [7:0] float_pat = 8'h55;

   // A pin that nobody drives or pulls wanders from cycle to cycle.
   always_ff @(posedge clk)
   begin
      float_pat <= ~float_pat;
   end

   // A driving module wins; otherwise the board may only sink a pin, else the pull-up decides.
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (pin_oe[i])
            level[i] = pin_out[i];
         else if (pull_low[i])
            level[i] = 1'b0;
         else if (pin_pullup[i])
            level[i] = 1'b1;
         else
            level[i] = float_pat[i];
      end
   end
endmodule : pxm_board

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench
   import pxm_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] wdata = 8'h00;
   logic [5:0] we = 6'h00;
   logic tx = 1'b0, sda_o = 1'b1, scl_o = 1'b1, cp0 = 1'b0;
   logic cp0a = 1'b0, sysclk = 1'b0;
   logic [2:0] cmp = 3'h0;
   logic [7:0] pull_low = 8'h00;
   logic rx_i, sda_i, scl_i, eci_i, t0_i, t1_i;
   logic [7:0] pin_in, pin_out, pin_oe, pin_pu, rx_en, port_rd, assigned;
   int fail_count = 0;
   int cmp_count = 0;

   initial
   begin
      forever #4 clk = ~clk;
   end

   pxm_port_mux dut (.CLK(clk), .RST(rst), .WDATA(wdata),
      .SKIP_WE(we[0]), .ROUTE_WE(we[1]), .CTRL_WE(we[2]),
      .IN_MODE_WE(we[3]), .OUT_MODE_WE(we[4]), .LATCH_WE(we[5]),
      .SERIAL_TRANSMIT_OUT(tx), .SDA_OUT(sda_o), .SCL_OUT(scl_o),
      .CP0_OUT(cp0), .CP0A_OUT(cp0a), .SYSCLK_OUT(sysclk),
      .COMPARE_OUT(cmp), .SERIAL_RECEIVE_IN(rx_i), .SDA_IN(sda_i),
      .SCL_IN(scl_i), .ECI_IN(eci_i), .T0_IN(t0_i), .T1_IN(t1_i),
      .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
      .PIN_PULLUP(pin_pu), .PIN_RX_EN(rx_en), .PORT_READ(port_rd),
      .PINS_ASSIGNED(assigned));

   pxm_board board (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pullup(pin_pu), .pull_low(pull_low), .level(pin_in));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Strobe index: 0 skip, 1 route, 2 ctrl, 3 in mode, 4 out mode, 5 latch.
   task automatic wr(input int k, input logic [7:0] d);
      @(posedge clk);
      wdata <= d;
      we <= 6'(1 << k);
      @(posedge clk);
      we <= 6'h00;
   endtask : wr

   task automatic settle;
      repeat (4) @(posedge clk);
      #1;
   endtask : settle

   task automatic stop_test;
      if (fail_count == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test

   task automatic t_reset;
      settle();
      chk(pin_oe, 8'h00);
      chk(rx_en, 8'hFF);
      chk(assigned, 8'h00);
      chk({2'b00, rx_i, sda_i, scl_i, eci_i, t0_i, t1_i}, 8'h38);
      chk(pin_pu, 8'hFF);
      chk(port_rd, 8'hFF);
   endtask : t_reset

   task automatic t_disabled;
      wr(4, 8'hFF);
      wr(1, 8'hFF);
      wr(2, 8'h07);
      settle();
      chk(pin_oe, 8'h00);
      chk(pin_pu, 8'h00);
   endtask : t_disabled

   task automatic t_skip;
      @(posedge clk);
      sda_o <= 1'b0;
      cp0 <= 1'b1;
      tx <= 1'b1;
      wr(0, 8'hC4);
      wr(1, 8'h9F);
      wr(2, 8'h47);
      settle();
      chk(assigned, 8'hBB);
      chk(pin_oe, 8'hFD);
      chk(pin_out & pin_oe, 8'h7C);
      chk(pin_pu, 8'h02);
      @(posedge clk);
      tx <= 1'b0;
      settle();
      chk(pin_out & pin_oe, 8'h6C);
   endtask : t_skip

   task automatic t_bus;
      @(posedge clk);
      sda_o <= 1'b1;
      pull_low <= 8'h21;
      wr(4, 8'h00);
      wr(0, 8'h00);
      wr(1, 8'h06);
      wr(2, 8'h47);
      settle();
      chk(assigned, 8'h3F);
      chk({2'b00, rx_i, sda_i, scl_i, eci_i, t0_i, t1_i}, 8'h0F);
      chk(port_rd, 8'hDE);
      @(posedge clk);
      pull_low <= 8'h00;
      wr(1, 8'h25);
      settle();
      chk(assigned, 8'h7F);
      chk(pin_oe, 8'h14);
      chk({7'h00, rx_i}, 8'h01);
   endtask : t_bus

   task automatic t_compare;
      logic [7:0] m;
      @(posedge clk);
      cmp <= 3'h5;
      wr(4, 8'hFF);
      wr(5, 8'h00);
      wr(2, 8'h40);
      for (int c = 0; c < 4; c++)
      begin
         wr(1, 8'(c << 6));
         settle();
         m = 8'((1 << c) - 1);
         chk(assigned, m);
         chk(pin_out, 8'h05 & m);
      end
   endtask : t_compare

   task automatic t_analog;
      // Software sets the pin modes, then skips analog pins 4 to 6; pin 7 cannot be skipped.
      wr(3, 8'h0F);
      wr(0, 8'hF0);
      wr(1, 8'h00);
      settle();
      chk(pin_oe, 8'h0F);
      chk(rx_en, 8'h0F);
      chk(pin_pu, 8'h00);
      chk(port_rd, 8'hF0);
      wr(4, 8'h00);
      wr(5, 8'hFF);
      settle();
      chk(pin_oe, 8'h00);
      chk(pin_pu, 8'h0F);
      wr(2, 8'hC0);
      settle();
      chk(pin_pu, 8'h00);
   endtask : t_analog

   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_disabled();
      t_skip();
      t_bus();
      t_compare();
      t_analog();
      // A reset in mid-run brings back every reset value.
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      stop_test();
   end

   initial
   begin
      repeat (5000) @(posedge clk);
      fail_count++;
      stop_test();
   end
endmodule : testbench
